// ---- gpio_pin_model.sv ----
`timescale 1ns/1ps
module gpio_pin_model (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] board_level,
    output logic [7:0] pad_in
);
    // Driven pins read back their own level, released pins show the board
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_level);
endmodule : gpio_pin_model

// ---- gpio_port_checker.sv ----
`timescale 1ns/1ps
module gpio_port_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic legacy_mode,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [7:0] port_a_pad_in,
    input wire logic [7:0] port_a_pad_out,
    input wire logic [7:0] port_a_pad_oe,
    input wire logic [7:0] port_c_pad_oe,
    input wire logic [7:0] port_f_pad_oe,
    input wire logic [4:0] port_g_pad_out
);
    // Bus requests only count while the clock enable is high
    wire logic wt = wr && ce;
    wire logic rt = rd && ce;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_a_lat; wt && addr == 5'h00 |=> port_a_pad_out == $past(wdata); endproperty
    a_a_lat: assert property (p_a_lat) else $error("port a latch");
    property p_a_dir; wt && addr == 5'h01 |=> port_a_pad_oe == $past(wdata); endproperty
    a_a_dir: assert property (p_a_dir) else $error("port a direction");
    property p_pin_wr; wt && addr == 5'h02 |=> $stable({port_a_pad_out, port_a_pad_oe});
    endproperty
    a_pin_wr: assert property (p_pin_wr) else $error("pin write stored");
    property p_pin_rd; rt && addr == 5'h02 |=> rdata == $past(port_a_pad_in); endproperty
    a_pin_rd: assert property (p_pin_rd) else $error("pin read");
    property p_g_lat; wt && addr == 5'h12 |=> port_g_pad_out == $past(wdata[4:0]); endproperty
    a_g_lat: assert property (p_g_lat) else $error("port g latch");
    property p_g_top; rt && addr[4:1] == 4'h9 |=> rdata[7:5] == 3'h0; endproperty
    a_g_top: assert property (p_g_top) else $error("port g upper bits");
    property p_c_leg; legacy_mode |-> port_c_pad_oe == 8'hff; endproperty
    a_c_leg: assert property (p_c_leg) else $error("legacy port c drive");
    property p_f_leg; legacy_mode && ce |=> port_f_pad_oe == 8'h00; endproperty
    a_f_leg: assert property (p_f_leg) else $error("legacy port f drive");
    c_a_lat: cover property (wt && addr == 5'h00);
    c_pin_rd: cover property (rt && addr == 5'h02);
    c_f_leg: cover property (legacy_mode && wt && addr == 5'h0f);
endmodule : gpio_port_checker
bind gpio_port_register_set gpio_port_checker i_gpio_port_checker (.clk(clk), .rst_b(rst_b),
    .ce(ce), .legacy_mode(legacy_mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port_a_pad_in(port_a_pad_in), .port_a_pad_out(port_a_pad_out),
    .port_a_pad_oe(port_a_pad_oe), .port_c_pad_oe(port_c_pad_oe),
    .port_f_pad_oe(port_f_pad_oe), .port_g_pad_out(port_g_pad_out));

// ---- gpio_port_params.svh ----
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

// ****************************************************************
// Register bus geometry
// ****************************************************************
`define GPIO_ADDR_WIDTH 5
`define GPIO_DATA_WIDTH 8

// ****************************************************************
// Register offsets, three per port for A to F
// ****************************************************************
`define OFS_PORT_A_OUTPUT_LATCH 5'h00
`define OFS_PORT_A_DIRECTION 5'h01
`define OFS_PORT_A_PIN_LEVELS 5'h02
`define OFS_PORT_B_OUTPUT_LATCH 5'h03
`define OFS_PORT_B_DIRECTION 5'h04
`define OFS_PORT_B_PIN_LEVELS 5'h05
`define OFS_PORT_C_OUTPUT_LATCH 5'h06
`define OFS_PORT_C_DIRECTION 5'h07
`define OFS_PORT_C_PIN_LEVELS 5'h08
`define OFS_PORT_D_OUTPUT_LATCH 5'h09
`define OFS_PORT_D_DIRECTION 5'h0a
`define OFS_PORT_D_PIN_LEVELS 5'h0b
`define OFS_PORT_E_OUTPUT_LATCH 5'h0c
`define OFS_PORT_E_DIRECTION 5'h0d
`define OFS_PORT_E_PIN_LEVELS 5'h0e
`define OFS_PORT_F_OUTPUT_LATCH 5'h0f
`define OFS_PORT_F_DIRECTION 5'h10
`define OFS_PORT_F_PIN_LEVELS 5'h11
`define OFS_PORT_G_OUTPUT_LATCH 5'h12
`define OFS_PORT_G_DIRECTION 5'h13

// ****************************************************************
// Field widths and reset values
// ****************************************************************
`define PORT_WIDTH 8
`define PORT_G_WIDTH 5
`define LATCH_RESET 8'h00
`define DIRECTION_RESET 8'h00
`define UNMAPPED_READ 8'h00

`endif

// ---- gpio_port_pkg.sv ----
package gpio_port_pkg;

    // ****************************************************************
    // Register selection decoded from the bus address
    // ****************************************************************
    typedef enum logic [1:0] {
        FIELD_LATCH = 2'b00,
        FIELD_DIRECTION = 2'b01,
        FIELD_PINS = 2'b10,
        FIELD_NONE = 2'b11
    } reg_field_type;

    typedef struct packed {
        logic [2:0] port;
        reg_field_type field;
    } reg_select_type;

endpackage : gpio_port_pkg

// ---- gpio_port_register_set.sv ----
`timescale 1ns/1ps
`include "gpio_port_params.svh"

// Notes on behaviour
// - Output latches of ports A to F are eight read/write bits that reset to zero.
// - Direction registers of ports A to F are eight read/write bits that reset to zero.
// - Pin level registers of ports A to F are read-only, writes store nothing, no reset value.
// - The port G latch keeps bits 4 to 0 writable, bits 7 to 5 read zero, all reset to zero.
// - The port G direction keeps bits 4 to 0 writable, bits 7 to 5 read zero, reset to zero.
// - In legacy mode the port C pins start as push-pull outputs driving zero.
// - In legacy mode port C reaches that driven-zero state with no clock edge needed.
// - In legacy mode port F has no latch or direction register and its pins are inputs only.
module gpio_port_register_set (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic legacy_mode,
    input wire logic [`GPIO_ADDR_WIDTH-1:0] addr,
    input wire logic [`GPIO_DATA_WIDTH-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`GPIO_DATA_WIDTH-1:0] rdata,
    input wire logic [`PORT_WIDTH-1:0] port_a_pad_in,
    output logic [`PORT_WIDTH-1:0] port_a_pad_out,
    output logic [`PORT_WIDTH-1:0] port_a_pad_oe,
    input wire logic [`PORT_WIDTH-1:0] port_b_pad_in,
    output logic [`PORT_WIDTH-1:0] port_b_pad_out,
    output logic [`PORT_WIDTH-1:0] port_b_pad_oe,
    input wire logic [`PORT_WIDTH-1:0] port_c_pad_in,
    output logic [`PORT_WIDTH-1:0] port_c_pad_out,
    output logic [`PORT_WIDTH-1:0] port_c_pad_oe,
    input wire logic [`PORT_WIDTH-1:0] port_d_pad_in,
    output logic [`PORT_WIDTH-1:0] port_d_pad_out,
    output logic [`PORT_WIDTH-1:0] port_d_pad_oe,
    input wire logic [`PORT_WIDTH-1:0] port_e_pad_in,
    output logic [`PORT_WIDTH-1:0] port_e_pad_out,
    output logic [`PORT_WIDTH-1:0] port_e_pad_oe,
    input wire logic [`PORT_WIDTH-1:0] port_f_pad_in,
    output logic [`PORT_WIDTH-1:0] port_f_pad_out,
    output logic [`PORT_WIDTH-1:0] port_f_pad_oe,
    output logic [`PORT_G_WIDTH-1:0] port_g_pad_out,
    output logic [`PORT_G_WIDTH-1:0] port_g_pad_oe
);
    import gpio_port_pkg::*;

    localparam int NUM_PORTS = 6;
    localparam int PORT_C = 2;
    localparam int PORT_F = 5;
    localparam logic [2:0] PORT_G_INDEX = 3'd6;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic reg_select_type decode_addr(input logic [`GPIO_ADDR_WIDTH-1:0] a);
        reg_select_type sel;
        sel.port = 3'd0;
        sel.field = FIELD_NONE;
        unique case (a)
            `OFS_PORT_A_OUTPUT_LATCH: sel = '{3'd0, FIELD_LATCH};
            `OFS_PORT_A_DIRECTION: sel = '{3'd0, FIELD_DIRECTION};
            `OFS_PORT_A_PIN_LEVELS: sel = '{3'd0, FIELD_PINS};
            `OFS_PORT_B_OUTPUT_LATCH: sel = '{3'd1, FIELD_LATCH};
            `OFS_PORT_B_DIRECTION: sel = '{3'd1, FIELD_DIRECTION};
            `OFS_PORT_B_PIN_LEVELS: sel = '{3'd1, FIELD_PINS};
            `OFS_PORT_C_OUTPUT_LATCH: sel = '{3'd2, FIELD_LATCH};
            `OFS_PORT_C_DIRECTION: sel = '{3'd2, FIELD_DIRECTION};
            `OFS_PORT_C_PIN_LEVELS: sel = '{3'd2, FIELD_PINS};
            `OFS_PORT_D_OUTPUT_LATCH: sel = '{3'd3, FIELD_LATCH};
            `OFS_PORT_D_DIRECTION: sel = '{3'd3, FIELD_DIRECTION};
            `OFS_PORT_D_PIN_LEVELS: sel = '{3'd3, FIELD_PINS};
            `OFS_PORT_E_OUTPUT_LATCH: sel = '{3'd4, FIELD_LATCH};
            `OFS_PORT_E_DIRECTION: sel = '{3'd4, FIELD_DIRECTION};
            `OFS_PORT_E_PIN_LEVELS: sel = '{3'd4, FIELD_PINS};
            `OFS_PORT_F_OUTPUT_LATCH: sel = '{3'd5, FIELD_LATCH};
            `OFS_PORT_F_DIRECTION: sel = '{3'd5, FIELD_DIRECTION};
            `OFS_PORT_F_PIN_LEVELS: sel = '{3'd5, FIELD_PINS};
            `OFS_PORT_G_OUTPUT_LATCH: sel = '{PORT_G_INDEX, FIELD_LATCH};
            `OFS_PORT_G_DIRECTION: sel = '{PORT_G_INDEX, FIELD_DIRECTION};
            default: sel = '{3'd0, FIELD_NONE};
        endcase
        return sel;
    endfunction : decode_addr

    reg_select_type sel;
    logic [`PORT_WIDTH-1:0] latch_q [0:NUM_PORTS-1];
    logic [`PORT_WIDTH-1:0] dir_q [0:NUM_PORTS-1];
    logic [`PORT_WIDTH-1:0] pad_in [0:NUM_PORTS-1];
    logic [`PORT_G_WIDTH-1:0] latch_g_q;
    logic [`PORT_G_WIDTH-1:0] dir_g_q;
    logic [`GPIO_DATA_WIDTH-1:0] rdata_next;

    assign sel = decode_addr(addr);

    assign pad_in[0] = port_a_pad_in;
    assign pad_in[1] = port_b_pad_in;
    assign pad_in[2] = port_c_pad_in;
    assign pad_in[3] = port_d_pad_in;
    assign pad_in[4] = port_e_pad_in;
    assign pad_in[5] = port_f_pad_in;

    // ****************************************************************
    // Ports A to F storage
    // ****************************************************************
    // Port F is held clear while legacy mode is selected, so its pins
    // fall back to inputs and no stale value reappears on leaving it.
    generate
        for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
            logic write_here;
            logic clear_here;
            assign write_here = wr && (sel.port == 3'(i));
            assign clear_here = (i == PORT_F) && legacy_mode;
            gpio_port_slice #(
                .WIDTH(`PORT_WIDTH)
            ) u_slice (
                .clk(clk),
                .rst_b(rst_b),
                .ce(ce),
                .clear(clear_here),
                .latch_we(write_here && (sel.field == FIELD_LATCH)),
                .dir_we(write_here && (sel.field == FIELD_DIRECTION)),
                .wdata(wdata),
                .latch_reg(latch_q[i]),
                .dir_reg(dir_q[i])
            );
        end
    endgenerate

    // ****************************************************************
    // Port G storage, five bits only
    // ****************************************************************
    gpio_port_slice #(
        .WIDTH(`PORT_G_WIDTH)
    ) u_slice_g (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .clear(1'b0),
        .latch_we(wr && (sel.port == PORT_G_INDEX) && (sel.field == FIELD_LATCH)),
        .dir_we(wr && (sel.port == PORT_G_INDEX) && (sel.field == FIELD_DIRECTION)),
        .wdata(wdata[`PORT_G_WIDTH-1:0]),
        .latch_reg(latch_g_q),
        .dir_reg(dir_g_q)
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Pin level selects have no write path at all: a write there is dropped.
    always_comb begin
        rdata_next = `UNMAPPED_READ;
        if (sel.port == PORT_G_INDEX) begin
            unique case (sel.field)
                FIELD_LATCH: rdata_next = {3'b000, latch_g_q};
                FIELD_DIRECTION: rdata_next = {3'b000, dir_g_q};
                default: rdata_next = `UNMAPPED_READ;
            endcase
        end else if (sel.port < 3'(NUM_PORTS)) begin
            unique case (sel.field)
                FIELD_LATCH: rdata_next = latch_q[sel.port];
                FIELD_DIRECTION: rdata_next = dir_q[sel.port];
                FIELD_PINS: rdata_next = pad_in[sel.port];
                FIELD_NONE: rdata_next = `UNMAPPED_READ;
            endcase
        end
    end

    // Read data stand from the enabled edge that takes the strobe until the next enabled edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= `UNMAPPED_READ;
        end else if (ce) begin
            rdata <= rd ? rdata_next : `UNMAPPED_READ;
        end
    end

    // ****************************************************************
    // Pad drive
    // ****************************************************************
    assign port_a_pad_out = latch_q[0];
    assign port_a_pad_oe = dir_q[0];
    assign port_b_pad_out = latch_q[1];
    assign port_b_pad_oe = dir_q[1];
    assign port_d_pad_out = latch_q[3];
    assign port_d_pad_oe = dir_q[3];
    assign port_e_pad_out = latch_q[4];
    assign port_e_pad_oe = dir_q[4];
    assign port_f_pad_out = latch_q[PORT_F];
    assign port_f_pad_oe = dir_q[PORT_F];
    assign port_g_pad_out = latch_g_q;
    assign port_g_pad_oe = dir_g_q;

    // Port C drive: legacy mode forces push-pull output without a clock.
    // The latch resets to zero, so the pins drive zero from reset onward;
    // the OR is the one output not taken straight from a flip-flop, as a
    // stopped clock must not delay it.
    assign port_c_pad_out = latch_q[PORT_C];
    assign port_c_pad_oe = dir_q[PORT_C] | {`PORT_WIDTH{legacy_mode}};

endmodule : gpio_port_register_set

// ---- gpio_port_register_set_tb.sv ----
`timescale 1ns/1ps
module gpio_port_register_set_tb;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, legacy_mode = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00, rdata, lat, dir;
    logic [7:0] pout [6], poe [6], pin [6];
    logic [4:0] g_out, g_oe;
    int err_count = 0, check_count = 0;
    always #4 clk = ~clk;
    gpio_port_register_set i_gpio_port_register_set (
        .clk(clk), .rst_b(rst_b), .ce(ce), .legacy_mode(legacy_mode), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .port_g_pad_out(g_out), .port_g_pad_oe(g_oe),
        .port_a_pad_in(pin[0]), .port_a_pad_out(pout[0]), .port_a_pad_oe(poe[0]),
        .port_b_pad_in(pin[1]), .port_b_pad_out(pout[1]), .port_b_pad_oe(poe[1]),
        .port_c_pad_in(pin[2]), .port_c_pad_out(pout[2]), .port_c_pad_oe(poe[2]),
        .port_d_pad_in(pin[3]), .port_d_pad_out(pout[3]), .port_d_pad_oe(poe[3]),
        .port_e_pad_in(pin[4]), .port_e_pad_out(pout[4]), .port_e_pad_oe(poe[4]),
        .port_f_pad_in(pin[5]), .port_f_pad_out(pout[5]), .port_f_pad_oe(poe[5]));
    // Each port sees its own board pattern so a crossed pin bus shows up
    for (genvar p = 0; p < 6; p++) begin : g_board
        gpio_pin_model i_gpio_pin_model (.pad_out(pout[p]), .pad_oe(poe[p]),
            .board_level(8'h96 ^ 8'(p)), .pad_in(pin[p]));
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic acc(input logic is_rd, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        {wr, rd, addr, wdata} <= {!is_rd, is_rd, a, d};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1;
        if (is_rd) chk($sformatf("reg %h", a), rdata, d);
    endtask : acc
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (4000) @(posedge clk);
        err_count++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        for (int p = 0; p < 6; p++) begin
            lat = 8'ha5 ^ 8'(p);
            dir = 8'h3c + 8'(p);
            acc(1, 5'(3 * p), 8'h00);
            acc(1, 5'(3 * p + 1), 8'h00);
            acc(0, 5'(3 * p), lat);
            acc(0, 5'(3 * p + 1), dir);
            acc(0, 5'(3 * p + 2), 8'hff);
            acc(1, 5'(3 * p), lat);
            acc(1, 5'(3 * p + 1), dir);
            acc(1, 5'(3 * p + 2), (dir & lat) | (~dir & (8'h96 ^ 8'(p))));
            chk("pad out", pout[p], lat);
            chk("pad oe", poe[p], dir);
        end
        acc(1, 5'h12, 8'h00);
        acc(1, 5'h13, 8'h00);
        acc(0, 5'h12, 8'hff);
        acc(0, 5'h13, 8'hea);
        acc(1, 5'h12, 8'h1f);
        acc(1, 5'h13, 8'h0a);
        chk("port g oe", {3'h0, g_oe}, 8'h0a);
        chk("port g out", {3'h0, g_out}, 8'h1f);
        acc(1, 5'h14, 8'h00);
        // A write while the clock enable is low must leave the latch alone
        @(posedge clk);
        ce <= 1'b0;
        acc(0, 5'h00, 8'h5a);
        @(posedge clk);
        ce <= 1'b1;
        acc(1, 5'h00, 8'ha5);
        chk("frozen latch", pout[0], 8'ha5);
        @(posedge clk);
        #1;
        chk("rdata idle", rdata, 8'h00);
        $display("test registers done");
        @(posedge clk);
        rst_b <= 1'b0;
        legacy_mode <= 1'b1;
        #1;
        chk("legacy c oe", poe[2], 8'hff);
        chk("legacy c out", pout[2], 8'h00);
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        acc(0, 5'h0f, 8'hff);
        acc(1, 5'h0f, 8'h00);
        acc(1, 5'h11, 8'h93);
        acc(0, 5'h06, 8'h81);
        chk("legacy c out", pout[2], 8'h81);
        $display("test legacy done");
        stop_test();
    end
endmodule : gpio_port_register_set_tb

// ---- gpio_port_slice.sv ----
`timescale 1ns/1ps
`include "gpio_port_params.svh"

module gpio_port_slice #(
    parameter int WIDTH = `PORT_WIDTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic clear,
    input wire logic latch_we,
    input wire logic dir_we,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] latch_reg,
    output logic [WIDTH-1:0] dir_reg
);

    // ****************************************************************
    // Output latch
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_reg <= '0;
        end else if (ce) begin
            if (clear) begin
                latch_reg <= '0;
            end else if (latch_we) begin
                latch_reg <= wdata;
            end
        end
    end

    // ****************************************************************
    // Direction register
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_reg <= '0;
        end else if (ce) begin
            if (clear) begin
                dir_reg <= '0;
            end else if (dir_we) begin
                dir_reg <= wdata;
            end
        end
    end

endmodule : gpio_port_slice
